//--- include/bsc_pkg.sv
// shared types and constants for the batch sequence controller
package bsc_pkg;

  localparam int unsigned BSC_STEPS = 16;
  localparam int unsigned BSC_OUTS = 8;
  localparam int unsigned BSC_STEP_W = 4;
  localparam logic [BSC_STEP_W-1:0] BSC_FIRST_STEP = 4'h0;
  localparam logic [BSC_OUTS-1:0] BSC_OUTS_RESET = 8'h00;

  // step kinds
  typedef enum logic [1:0] {
    BSC_KIND_BATCH = 2'b00,
    BSC_KIND_CONT = 2'b01,
    BSC_KIND_CONCURRENT_STEP = 2'b10,
    BSC_KIND_TIMER = 2'b11
  } bsc_kind_t;

  typedef enum logic [1:0] {
    BSC_ST_IDLE = 2'b00,
    BSC_ST_RUN = 2'b01,
    BSC_ST_PAUSE = 2'b10,
    BSC_ST_STOP = 2'b11
  } bsc_state_t;

  // serial commands as decoded by the front end
  typedef enum logic [2:0] {
    BSC_CMD_START = 3'h0,
    BSC_CMD_PAUSE = 3'h1,
    BSC_CMD_STOP = 3'h2,
    BSC_CMD_RESET = 3'h3,
    BSC_CMD_OTHER = 3'h4
  } bsc_cmd_t;

  typedef struct packed {
    logic valid;
    bsc_cmd_t cmd;
  } bsc_ser_req_t;

  typedef struct packed {
    logic valid;
    logic ok;
  } bsc_ser_rsp_t;

  // batching switch: stop locked in, selector positions
  typedef struct packed {
    logic stop_in;
    logic sel_abort;
    logic sel_start;
  } bsc_switch_t;

endpackage

//--- logic/bsc_batch_ctrl.sv
// batch sequence controller: softkeys, batching switch, serial acks, output gating
`timescale 1ns/1ns
module bsc_batch_ctrl
  import bsc_pkg::*;
#(
  parameter int unsigned STEPS = BSC_STEPS,
  parameter int unsigned OUTS = BSC_OUTS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // operator softkeys, one-cycle pulses
  input wire logic key_start_i,
  input wire logic key_pause_i,
  input wire logic key_reset_i,
  input wire logic key_stop_i,
  // batching switch on its own inputs, plus run-input assignment
  input wire bsc_switch_t sw_i,
  input wire logic run_input_assigned_i,
  // step configuration and live condition from setpoint logic
  input wire bsc_kind_t step_kind_i [STEPS],
  input wire logic [OUTS-1:0] step_out_sel_i [STEPS],
  input wire logic [STEPS-1:0] step_met_i,
  input wire logic [BSC_STEP_W-1:0] last_step_i,
  // serial command port
  input wire bsc_ser_req_t ser_req_i,
  output bsc_ser_rsp_t ser_rsp_o,
  // batch outputs and status
  output logic [OUTS-1:0] batch_out_o,
  output logic [BSC_STEP_W-1:0] step_ptr_o,
  output bsc_state_t state_o
);

  initial begin
    if (STEPS < 2 || STEPS > (1 << BSC_STEP_W) || OUTS < 1) begin
      $error("bsc_batch_ctrl: unsupported STEPS or OUTS");
    end
  end

  bsc_state_t state_q;
  logic [BSC_STEP_W-1:0] ptr_q;
  logic [OUTS-1:0] out_q;
  logic [OUTS-1:0] saved_q;
  logic start_prev_q;
  logic abort_seen_q;
  bsc_ser_rsp_t rsp_q;

  logic active;
  logic stop_locked;
  logic sw_start_edge;
  logic ser_start;
  logic ser_pause;
  logic ser_stop;
  logic ser_reset;
  logic do_start;
  logic do_pause;
  logic do_stop;
  logic do_reset;
  logic [OUTS-1:0] keep_mask;
  logic [OUTS-1:0] step_drive;
  logic step_done;
  bsc_kind_t cur_kind;

  assign active = (state_q == BSC_ST_RUN) || (state_q == BSC_ST_PAUSE);

  assign stop_locked = run_input_assigned_i && sw_i.stop_in;

  assign sw_start_edge = sw_i.sel_start && !start_prev_q;

  assign ser_start = ser_req_i.valid && ser_req_i.cmd == BSC_CMD_START;
  assign ser_pause = ser_req_i.valid && ser_req_i.cmd == BSC_CMD_PAUSE;
  assign ser_stop = ser_req_i.valid && ser_req_i.cmd == BSC_CMD_STOP;
  assign ser_reset = ser_req_i.valid && ser_req_i.cmd == BSC_CMD_RESET;

  assign do_start = key_start_i || ser_start || (sw_start_edge && !stop_locked);
  assign do_stop = key_stop_i || ser_stop || stop_locked;
  assign do_pause = key_pause_i || ser_pause;
  assign do_reset = key_reset_i || ser_reset;

  assign cur_kind = step_kind_i[ptr_q];
  assign step_done = step_met_i[ptr_q];

  // outputs owned by concurrent and timer steps survive a pause
  always_comb begin
    keep_mask = '0;
    step_drive = '0;
    for (int i = 0; i < STEPS; i++) begin
      if (step_kind_i[i] == BSC_KIND_CONCURRENT_STEP || step_kind_i[i] == BSC_KIND_TIMER) begin
        keep_mask = keep_mask | step_out_sel_i[i];
      end
    end
    // continuous on when met, batch until met
    if (cur_kind == BSC_KIND_CONT) begin
      step_drive = step_done ? step_out_sel_i[ptr_q] : '0;
    end else if (cur_kind == BSC_KIND_BATCH) begin
      step_drive = step_done ? '0 : step_out_sel_i[ptr_q];
    end else begin
      step_drive = step_out_sel_i[ptr_q];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= sw_i.sel_start;
    end
  end

  // abort remembered until the next start from key, serial port or switch clears it
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      abort_seen_q <= 1'b0;
    end else if (sw_i.sel_abort) begin
      abort_seen_q <= 1'b1;
    end else if (do_start) begin
      abort_seen_q <= 1'b0;
    end
  end

  // state machine; stop outranks reset, reset outranks pause and start
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= BSC_ST_IDLE;
    end else begin
      case (state_q)
        BSC_ST_RUN: begin
          if (do_stop) begin
            state_q <= BSC_ST_STOP;
          end else if (do_reset) begin
            state_q <= BSC_ST_IDLE;
          end else if (do_pause) begin
            state_q <= BSC_ST_PAUSE;
          end else if (step_done && ptr_q == last_step_i) begin
            state_q <= BSC_ST_IDLE;
          end
        end
        BSC_ST_PAUSE: begin
          if (do_stop) begin
            state_q <= BSC_ST_STOP;
          end else if (do_reset) begin
            state_q <= BSC_ST_IDLE;
          end else if (do_start) begin
            state_q <= BSC_ST_RUN;
          end
        end
        BSC_ST_STOP, BSC_ST_IDLE: begin
          if (do_start && !stop_locked) begin
            state_q <= BSC_ST_RUN;
          end
        end
        default: begin
          state_q <= BSC_ST_IDLE;
        end
      endcase
    end
  end

  // step pointer
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ptr_q <= BSC_FIRST_STEP;
    end else if (active && do_reset && !do_stop) begin
      ptr_q <= BSC_FIRST_STEP;
    end else if (!active && do_start && !stop_locked && abort_seen_q) begin
      ptr_q <= BSC_FIRST_STEP;
    end else if (state_q == BSC_ST_RUN && !do_stop && !do_reset && !do_pause && step_done) begin
      if (ptr_q == last_step_i) begin
        ptr_q <= BSC_FIRST_STEP;
      end else begin
        ptr_q <= ptr_q + 1'b1;
      end
    end
  end

  // batch outputs and pause save set
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      out_q <= BSC_OUTS_RESET;
      saved_q <= BSC_OUTS_RESET;
    end else if (active && do_stop) begin
      out_q <= '0;
      saved_q <= '0;
    end else if (active && do_reset) begin
      out_q <= '0;
      saved_q <= '0;
    end else if (state_q == BSC_ST_RUN && do_pause) begin
      // drop all but concurrent and timer
      out_q <= out_q & keep_mask;
      saved_q <= out_q & ~keep_mask;
    end else if (state_q == BSC_ST_PAUSE && do_start) begin
      out_q <= out_q | saved_q;
      saved_q <= '0;
    end else if (state_q == BSC_ST_RUN) begin
      out_q <= (out_q & keep_mask) | step_drive;
    end
  end

  // serial reply one cycle after each command
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= ser_req_i.valid;
      case (ser_req_i.cmd)
        BSC_CMD_START: rsp_q.ok <= !stop_locked && state_q != BSC_ST_RUN;
        BSC_CMD_PAUSE: rsp_q.ok <= state_q == BSC_ST_RUN;
        BSC_CMD_STOP: rsp_q.ok <= active;
        BSC_CMD_RESET: rsp_q.ok <= 1'b1;
        default: rsp_q.ok <= 1'b0;
      endcase
    end
  end

  assign ser_rsp_o = rsp_q;
  assign batch_out_o = out_q;
  assign step_ptr_o = ptr_q;
  assign state_o = state_q;

endmodule

//--- sim/bsc_checker.sv
// port assertions for the batch sequence controller
`timescale 1ns/1ns
module bsc_checker
  import bsc_pkg::*;
(
  // clock and reset
  input logic clk_i,
  input logic reset_n_i,
  // requests
  input logic key_start_i,
  input logic key_pause_i,
  input logic key_reset_i,
  input logic key_stop_i,
  input bsc_switch_t sw_i,
  input logic run_input_assigned_i,
  input bsc_ser_req_t ser_req_i,
  // results
  input bsc_ser_rsp_t ser_rsp_o,
  input logic [BSC_OUTS-1:0] batch_out_o,
  input logic [BSC_STEP_W-1:0] step_ptr_o,
  input bsc_state_t state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic lk;
  logic kk;
  assign lk = sw_i.stop_in && run_input_assigned_i;
  assign kk = key_stop_i || key_reset_i || key_pause_i || ser_req_i.valid;
  // idle, unlocked, nothing competing with a start
  sequence s_free_idle;
    state_o == BSC_ST_IDLE && !lk && !kk;
  endsequence
  chk_serial_reply: assert property (ser_req_i.valid |=> ser_rsp_o.valid)
    else $error("serial request got no reply");
  chk_reset_ok: assert property (ser_req_i.valid && ser_req_i.cmd == BSC_CMD_RESET |=> ser_rsp_o.ok)
    else $error("serial reset not acknowledged");
  chk_other_fails: assert property (ser_req_i.valid && ser_req_i.cmd == BSC_CMD_OTHER |=> !ser_rsp_o.ok)
    else $error("unknown serial command acknowledged");
  chk_key_start: assert property (s_free_idle ##0 key_start_i |=> state_o == BSC_ST_RUN)
    else $error("start key did not run batch");
  chk_sel_start: assert property (s_free_idle ##0 $rose(sw_i.sel_start) |=> state_o == BSC_ST_RUN)
    else $error("selector pulse did not run batch");
  // a serial stop or reset in the same cycle outranks the pause key
  chk_pause_holds: assert property (state_o == BSC_ST_RUN && key_pause_i && !key_stop_i && !key_reset_i && !lk
    && !ser_req_i.valid
    |=> state_o == BSC_ST_PAUSE) else $error("pause not taken");
  chk_stop_clears: assert property (key_stop_i && state_o inside {BSC_ST_RUN, BSC_ST_PAUSE}
    |=> state_o == BSC_ST_STOP && batch_out_o == '0) else $error("stop left outputs on");
  chk_reset_home: assert property (key_reset_i && !key_stop_i && state_o inside {BSC_ST_RUN, BSC_ST_PAUSE}
    && !lk && !ser_req_i.valid
    |=> step_ptr_o == BSC_FIRST_STEP) else $error("reset did not home pointer");
  chk_lock_halts: assert property (lk && state_o == BSC_ST_RUN |=> state_o == BSC_ST_STOP)
    else $error("locked stop did not halt");
  chk_lock_blocks: assert property (lk && state_o != BSC_ST_RUN && !key_start_i && !ser_req_i.valid
    |=> state_o != BSC_ST_RUN) else $error("start taken while locked");
  chk_idle_quiet: assert property (state_o == BSC_ST_IDLE && kk && !ser_req_i.valid && !key_start_i
    && !sw_i.sel_start |=> $stable(step_ptr_o) && $stable(batch_out_o)) else $error("idle request changed state");
endmodule

bind bsc_batch_ctrl bsc_checker u_chk (.clk_i, .reset_n_i, .key_start_i, .key_pause_i, .key_reset_i, .key_stop_i,
  .sw_i, .run_input_assigned_i, .ser_req_i, .ser_rsp_o, .batch_out_o, .step_ptr_o, .state_o);

//--- sim/bsc_switch_model.sv
// batching switch contacts as the operator works them
`timescale 1ns/1ns
module bsc_switch_model
  import bsc_pkg::*;
(
  // operator actions
  input logic lock_i,
  input logic abort_i,
  input logic push_i,
  // switch contacts
  output bsc_switch_t sw_o
);
  // separate momentary contacts
  // the selector cannot sit at abort and start together
  assign sw_o = '{stop_in: lock_i, sel_abort: abort_i, sel_start: push_i && !abort_i};
endmodule

//--- sim/tb_top.sv
// self-checking bench for the batch sequence controller
`timescale 1ns/1ns
module tb_top;
  import bsc_pkg::*;
  logic clk_i = 0, reset_n_i = 0, run_i = 1, lock = 0, abort = 0, push = 0;
  logic [3:0] k = 0;
  logic [15:0] met = 0;
  bsc_kind_t kind [BSC_STEPS];
  logic [7:0] sel [BSC_STEPS];
  bsc_ser_req_t req = 0;
  bsc_ser_rsp_t rsp;
  bsc_switch_t sw;
  logic [7:0] out;
  logic [3:0] ptr;
  bsc_state_t st;
  int mismatches = 0, comparisons = 0, cycles = 0;
  logic [31:0] seed = 93389;
  bsc_cmd_t cmds [7] = '{BSC_CMD_PAUSE, BSC_CMD_STOP, BSC_CMD_OTHER, BSC_CMD_RESET, BSC_CMD_START, BSC_CMD_PAUSE,
    BSC_CMD_STOP};
  logic [6:0] oks = 7'h78;
  bsc_switch_model u_sw (.lock_i(lock), .abort_i(abort), .push_i(push), .sw_o(sw));
  bsc_batch_ctrl DUT (.clk_i, .reset_n_i, .key_start_i(k[0]), .key_pause_i(k[1]), .key_reset_i(k[2]),
    .key_stop_i(k[3]), .sw_i(sw), .run_input_assigned_i(run_i), .step_kind_i(kind), .step_out_sel_i(sel),
    .step_met_i(met), .last_step_i(4'hF), .ser_req_i(req), .ser_rsp_o(rsp), .batch_out_o(out),
    .step_ptr_o(ptr), .state_o(st));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // a batch step drives its outputs until met, a continuous one only once met
  function automatic logic [7:0] drive(input logic [3:0] p);
    return kind[p] == BSC_KIND_BATCH ? sel[p] : 8'h00;
  endfunction
  task ck(input logic ok);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t: mismatch", $time);
    end
  endtask
  task wrap_up;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task key(input logic [3:0] v);
    k = v;
    @(negedge clk_i);
    k = 0;
  endtask
  task go;
    push = 1;
    @(negedge clk_i);
    push = 0;
  endtask
  task ser(input bsc_cmd_t c, input logic ok);
    req = '{1'b1, c};
    @(negedge clk_i);
    req = 0;
    ck(rsp.valid === 1'b1 && rsp.ok === ok);
  endtask
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      wrap_up;
    end
  end
  initial begin
    for (int i = 0; i < BSC_STEPS; i++) begin
      seed = xs(seed);
      kind[i] = BSC_KIND_BATCH;
      sel[i] = seed[7:0] | 8'h01;
    end
    repeat (2) @(negedge clk_i);
    reset_n_i = 1;
    key(4'h2);
    ck(ptr === 4'h0 && out === 8'h00);
    for (int i = 0; i < 7; i++) ser(cmds[i], oks[i]);
    key(4'h1);
    ck(st === BSC_ST_RUN && ptr === 4'h0);
    @(negedge clk_i);
    ck(out === drive(4'h0));
    key(4'h2);
    ck(st === BSC_ST_PAUSE && out === 8'h00);
    key(4'h1);
    ck(st === BSC_ST_RUN && out === drive(4'h0));
    met = 16'h0001;
    @(negedge clk_i);
    met = 0;
    lock = 1;
    @(negedge clk_i);
    ck(st === BSC_ST_STOP && out === 8'h00);
    go();
    ck(st === BSC_ST_STOP);
    lock = 0;
    @(negedge clk_i);
    go();
    ck(st === BSC_ST_RUN && ptr === 4'h1);
    lock = 1;
    @(negedge clk_i);
    abort = 1;
    @(negedge clk_i);
    abort = 0;
    lock = 0;
    @(negedge clk_i);
    go();
    ck(st === BSC_ST_RUN && ptr === 4'h0);
    met = 16'h0001;
    @(negedge clk_i);
    met = 0;
    key(4'h4);
    ck(ptr === 4'h0);
    key(4'h1);
    key(4'h8);
    ck(st === BSC_ST_STOP && out === 8'h00);
    // with no run input assigned a locked button must not block the start
    run_i = 0;
    lock = 1;
    @(negedge clk_i);
    go();
    ck(st === BSC_ST_RUN);
    wrap_up;
  end
endmodule
